/* File: rsdp_defs.svh */
// offsets, field positions, reset values and decode codes of the datapath
`ifndef RSDP_DEFS_SVH
`define RSDP_DEFS_SVH

// printed register indices, byte address is four times the index
`define RSDP_STATUS_IDX   12'h0583
`define RSDP_WORKING_REGISTER_IDX     12'h0589
`define RSDP_STATUS_ADDR  16'h160C
`define RSDP_WORKING_REGISTER_ADDR    16'h1624
// locally placed registers
`define RSDP_CTRL_ADDR    16'h1700
`define RSDP_INSTR_ADDR   16'h1704
`define RSDP_WDOG_ADDR    16'h1708
// file register window: byte 0x0000..0x01FC, one word per entry
`define RSDP_FILE_TOP     7'h00

// status and control field positions
`define RSDP_ST_C         0
`define RSDP_ST_DC        1
`define RSDP_ST_Z         2
`define RSDP_ST_PD        3
`define RSDP_ST_TO        4
`define RSDP_CTRL_WDEN    0

// reset values
`define RSDP_WORKING_REGISTER_RST     8'h00
`define RSDP_FLAG_RST     1'b0
`define RSDP_TOPD_RST     1'b1

// opcode heads in bits 13:8 of the 14-bit instruction word, the whole sleep word and the destination bit
`define RSDP_OP_ROTL      6'h0D
`define RSDP_OP_ROTR      6'h0C
`define RSDP_OP_SUBF      6'h02
`define RSDP_OP_SUBL      6'h3C
`define RSDP_OP_SLEEP     14'h0063
`define RSDP_DEST_BIT     7

// watchdog prescaler terminal count
`define RSDP_PRE_TOP      8'hFF

`endif

/* File: rsdp_pkg.sv */
// types used by the datapath core module
package rsdp_pkg;

    // executor sequence
    typedef enum logic [1:0] {
        EX_IDLE,
        EX_FETCH,
        EX_EXEC
    } rsdp_exst_t;

    // decoded operation
    typedef enum logic [2:0] {
        OP_NONE,
        OP_ROTL,
        OP_ROTR,
        OP_SUBL,
        OP_SUBF,
        OP_SLEEP
    } rsdp_op_t;

endpackage : rsdp_pkg

/* File: rsdp_filemem.sv */
// file register store, 128 bytes, registered read
`timescale 1ns/100ps
module rsdp_filemem (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [6:0] raddr,
    output logic      [7:0] rdata_q
);
    logic [7:0] mem [0:127];   // storage array

    // write port, no reset on the array
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // read port, data one cycle after the address
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule : rsdp_filemem

/* File: rsdp_core.sv */
// rotate, subtract and sleep datapath with ahb-lite register slave
`timescale 1ns/100ps
`include "rsdp_defs.svh"

// Summary of operation
// - rotate left through carry, only carry updated
// - rotate right through carry, only carry updated
// - rotate destination bit: 0 working, 1 file
// - sleep clears powerdown, sets timeout, clears watchdog
// - literal minus working into working, flags updated
// - carry and nibble carry are not-borrow
// - file minus working, destination bit selects target
module rsdp_core (
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic        CE,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic             ASLEEP
);
    // bus data-phase state
    logic        dp_valid_q;          // transfer pending
    logic        dp_go_q;             // access issued, answer next
    logic        dp_write_q;          // pending transfer is a write
    logic [15:0] dp_addr_q;           // pending byte address
    logic [31:0] hrdata_q;            // read data to master
    logic        hreadyout_q;         // ready to master
    logic        hresp_q;             // always okay

    // architectural state
    logic [7:0]  w_q;                 // working register
    logic        c_q;                 // carry
    logic        dc_q;                // nibble carry
    logic        z_q;                 // zero
    logic        to_n_q;              // timeout status, active low
    logic        pd_n_q;              // powerdown status, active low
    logic        wden_q;              // watchdog counting enable
    logic        asleep_q;            // core asleep
    logic [7:0]  pre_q;               // watchdog prescaler
    logic [7:0]  wdog_q;              // watchdog counter
    logic [13:0] instr_q;             // instruction under execution
    rsdp_pkg::rsdp_exst_t st_q;       // executor state

    // bus decode
    wire addr_take  = HSEL && HREADY && HTRANS[1];
    wire busy       = (st_q != rsdp_pkg::EX_IDLE);
    wire dp_issue   = dp_valid_q && !dp_go_q && !busy;
    wire bus_wr     = dp_issue && dp_write_q;
    wire hit_mem    = (dp_addr_q[15:9] == `RSDP_FILE_TOP);
    wire hit_status = (dp_addr_q == `RSDP_STATUS_ADDR);
    wire hit_working_register   = (dp_addr_q == `RSDP_WORKING_REGISTER_ADDR);
    wire hit_ctrl   = (dp_addr_q == `RSDP_CTRL_ADDR);
    wire hit_instr  = (dp_addr_q == `RSDP_INSTR_ADDR);
    wire hit_wdog   = (dp_addr_q == `RSDP_WDOG_ADDR);
    wire start      = bus_wr && hit_instr;

    // memory port wiring
    logic [7:0] mem_rdata;            // registered file read data
    wire  [7:0] status_rd = {3'h0, to_n_q, pd_n_q, z_q, dc_q, c_q};

    // read word selection, unmapped reads give zero
    wire [31:0] rd_word =
        hit_mem    ? {24'h00_0000, mem_rdata} :
        hit_status ? {24'h00_0000, status_rd} :
        hit_working_register   ? {24'h00_0000, w_q} :
        hit_ctrl   ? {24'h00_0000, 6'h00, asleep_q, wden_q} :
        hit_instr  ? {18'h0_0000, instr_q} :
        hit_wdog   ? {16'h0000, wdog_q, pre_q} : 32'h0000_0000;

    // decode of the held instruction
    wire [5:0] op_head = instr_q[13:8];
    wire rsdp_pkg::rsdp_op_t op =
        (instr_q == `RSDP_OP_SLEEP)   ? rsdp_pkg::OP_SLEEP :
        (op_head == `RSDP_OP_ROTL)    ? rsdp_pkg::OP_ROTL :
        (op_head == `RSDP_OP_ROTR)    ? rsdp_pkg::OP_ROTR :
        (op_head == `RSDP_OP_SUBL)    ? rsdp_pkg::OP_SUBL :
        (op_head == `RSDP_OP_SUBF)    ? rsdp_pkg::OP_SUBF : rsdp_pkg::OP_NONE;
    wire is_rot   = (op == rsdp_pkg::OP_ROTL) || (op == rsdp_pkg::OP_ROTR);
    wire is_sub   = (op == rsdp_pkg::OP_SUBL) || (op == rsdp_pkg::OP_SUBF);
    wire is_sleep = (op == rsdp_pkg::OP_SLEEP);
    wire dest_f   = instr_q[`RSDP_DEST_BIT];

    // rotate through carry
    wire [7:0] rotl_res = {mem_rdata[6:0], c_q};
    wire [7:0] rotr_res = {c_q, mem_rdata[7:1]};

    // subtract by adding the complement plus one
    wire [7:0] sub_a    = (op == rsdp_pkg::OP_SUBL) ? instr_q[7:0] : mem_rdata;
    wire [8:0] sub_full = {1'b0, sub_a} + {1'b0, ~w_q} + 9'h001;
    wire [4:0] sub_nib  = {1'b0, sub_a[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;

    // result and flag selection
    wire [7:0] exec_res =
        (op == rsdp_pkg::OP_ROTL) ? rotl_res :
        (op == rsdp_pkg::OP_ROTR) ? rotr_res : sub_full[7:0];
    wire exec_c  = (op == rsdp_pkg::OP_ROTL) ? mem_rdata[7] :
                   (op == rsdp_pkg::OP_ROTR) ? mem_rdata[0] : sub_full[8];
    wire exec_dc = sub_nib[4];
    wire exec_z  = (sub_full[7:0] == 8'h00);

    // destinations
    wire exec_fire    = (st_q == rsdp_pkg::EX_EXEC);
    wire exec_wr_file = exec_fire && dest_f && (is_rot || op == rsdp_pkg::OP_SUBF);
    wire exec_wr_w    = exec_fire && (op == rsdp_pkg::OP_SUBL ||
                        (!dest_f && (is_rot || op == rsdp_pkg::OP_SUBF)));
    wire exec_sleep   = exec_fire && is_sleep;

    // shared memory port, bus only while the executor is idle
    wire       mem_we    = exec_wr_file || (bus_wr && hit_mem);
    wire [6:0] mem_waddr = busy ? instr_q[6:0] : dp_addr_q[8:2];
    wire [7:0] mem_wdata = busy ? exec_res : HWDATA[7:0];
    wire [6:0] mem_raddr = (st_q == rsdp_pkg::EX_FETCH) ? instr_q[6:0] : dp_addr_q[8:2];

    // file register store
    rsdp_filemem u_mem (
        .clk     (CLOCK),
        .rst_n   (RSTN),
        .ce      (CE),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata_q (mem_rdata)
    );

    // ahb-lite slave: take, issue, answer
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            dp_valid_q  <= 1'b0;
            dp_go_q     <= 1'b0;
            dp_write_q  <= 1'b0;
            dp_addr_q   <= 16'h0000;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else if (CE) begin
            if (addr_take) begin
                // address phase accepted, wait state follows
                dp_valid_q  <= 1'b1;
                dp_write_q  <= HWRITE;
                dp_addr_q   <= HADDR[15:0];
                hreadyout_q <= 1'b0;
            end else if (dp_issue) begin
                // access made this cycle
                dp_go_q <= 1'b1;
            end else if (dp_go_q) begin
                // answer with data
                dp_valid_q  <= 1'b0;
                dp_go_q     <= 1'b0;
                hrdata_q    <= rd_word;
                hreadyout_q <= 1'b1;
            end
        end
    end

    // executor sequence: fetch operand, then execute
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            st_q    <= rsdp_pkg::EX_IDLE;
            instr_q <= 14'h0000;
        end else if (CE) begin
            case (st_q)
                rsdp_pkg::EX_IDLE: begin
                    if (start) begin
                        instr_q <= HWDATA[13:0];
                        st_q    <= rsdp_pkg::EX_FETCH;
                    end
                end
                rsdp_pkg::EX_FETCH: st_q <= rsdp_pkg::EX_EXEC;
                rsdp_pkg::EX_EXEC:  st_q <= rsdp_pkg::EX_IDLE;
                default:            st_q <= rsdp_pkg::EX_IDLE;
            endcase
        end
    end

    // working register and status flags
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            w_q    <= `RSDP_WORKING_REGISTER_RST;
            c_q    <= `RSDP_FLAG_RST;
            dc_q   <= `RSDP_FLAG_RST;
            z_q    <= `RSDP_FLAG_RST;
            to_n_q <= `RSDP_TOPD_RST;
            pd_n_q <= `RSDP_TOPD_RST;
        end else if (CE) begin
            if (exec_fire) begin
                if (exec_wr_w) begin
                    w_q <= exec_res;
                end
                if (is_rot || is_sub) begin
                    c_q <= exec_c;
                end
                if (is_sub) begin
                    dc_q <= exec_dc;
                    z_q  <= exec_z;
                end
                if (is_sleep) begin
                    to_n_q <= 1'b1;
                    pd_n_q <= 1'b0;
                end
            end else if (bus_wr && hit_working_register) begin
                w_q <= HWDATA[7:0];
            end else if (bus_wr && hit_status) begin
                // status bits 4:3 are read only
                c_q  <= HWDATA[`RSDP_ST_C];
                dc_q <= HWDATA[`RSDP_ST_DC];
                z_q  <= HWDATA[`RSDP_ST_Z];
            end
        end
    end

    // control register and sleep indication
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            wden_q   <= 1'b0;
            asleep_q <= 1'b0;
        end else if (CE) begin
            if (exec_sleep) begin
                asleep_q <= 1'b1;
            end else if (bus_wr && hit_ctrl) begin
                // any control write wakes the core
                wden_q   <= HWDATA[`RSDP_CTRL_WDEN];
                asleep_q <= 1'b0;
            end
        end
    end

    // watchdog prescaler and counter
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            pre_q  <= 8'h00;
            wdog_q <= 8'h00;
        end else if (CE) begin
            if (exec_sleep) begin
                pre_q  <= 8'h00;
                wdog_q <= 8'h00;
            end else if (wden_q) begin
                pre_q <= pre_q + 8'h01;
                if (pre_q == `RSDP_PRE_TOP) begin
                    wdog_q <= wdog_q + 8'h01;
                end
            end
        end
    end

    // outputs straight from flops
    assign HRDATA    = hrdata_q;
    assign HREADYOUT = hreadyout_q;
    assign HRESP     = hresp_q;
    assign ASLEEP    = asleep_q;
endmodule : rsdp_core

/* File: rsdp_core_properties.sv */
// port-level checker for the rotate subtract sleep datapath
`timescale 1ns/100ps
`include "rsdp_defs.svh"
module rsdp_chk (
    input wire logic        CLOCK,
    input wire logic        RSTN,
    input wire logic        CE,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        ASLEEP
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // address phase accepted by the slave
    sequence s_take;
        CE && HSEL && HREADY && HTRANS[1];
    endsequence
    // sleep opcode written to the instruction register
    sequence s_sleep_wr;
        s_take ##0 (HWRITE && HADDR[15:0] == `RSDP_INSTR_ADDR) ##1 HWDATA[13:0] == `RSDP_OP_SLEEP;
    endsequence
    chk_ready_drop: assert property (s_take |=> !HREADYOUT)
        else $error("hreadyout high after accepted address");
    chk_ready_bound: assert property (s_take |-> ##[2:8] HREADYOUT)
        else $error("data phase did not end in time");
    chk_resp_okay: assert property (HRESP == 1'b0)
        else $error("response not okay");
    chk_sleep_set: assert property (s_sleep_wr |-> ##[1:8] ASLEEP)
        else $error("sleep level not raised");
    chk_sleep_hold: assert property (ASLEEP && HREADYOUT && !(HSEL && HTRANS[1]) |=> ASLEEP)
        else $error("sleep level dropped without a write");
    chk_rdata_hold: assert property (!$rose(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data changed outside an answer");
    chk_upper_zero: assert property (HRDATA[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_reset_vals: assert property (disable iff (1'b0) !RSTN && CE |=>
        HREADYOUT && HRDATA == 32'h0000_0000 && !ASLEEP)
        else $error("outputs wrong after reset");
endmodule : rsdp_chk
bind rsdp_core rsdp_chk u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ASLEEP(ASLEEP));

/* File: testbench.sv */
// self-checking bench for the rotate subtract sleep datapath
`timescale 1ns/100ps
`include "rsdp_defs.svh"
module testbench;
    logic        CLOCK  = 1'b0;          // core clock
    logic        RSTN   = 1'b0;          // reset, active low
    logic        HSEL   = 1'b0;          // slave select
    logic [31:0] HADDR  = 32'h0000_0000; // byte address
    logic [1:0]  HTRANS = 2'b00;         // transfer type
    logic        HWRITE = 1'b0;          // direction
    logic [31:0] HWDATA = 32'h0000_0000; // write data
    logic [31:0] HRDATA;                 // read data
    logic        HREADYOUT;              // slave ready, also bus ready
    logic        HRESP;                  // response
    logic        ASLEEP;                 // sleep level
    int          n_errors = 0;           // mismatches
    int          checks_done = 0;        // comparisons
    int          cyc = 0;                // cycle count
    integer      seed = 32'h9984;        // fixed seed
    logic [31:0] rd;                     // last read data
    logic [1:0]  op;                     // 0 rotl, 1 rotr, 2 file minus, 3 literal minus
    logic        dd;                     // destination bit
    logic [6:0]  f;                      // file address
    logic [7:0]  w, k, fv;               // working, literal, file value
    logic [2:0]  st;                     // z dc c before
    logic [10:0] e;                      // expected z dc c result
    logic [5:0]  hd;                     // opcode head
    logic [13:0] ins;                    // instruction word
    logic        tw;                     // result goes to working
    logic        CE     = 1'b1;          // clock enable, low freezes the core
    logic [63:0] rnd;                    // two random words per operation
    logic [15:0] v0;                     // watchdog word before a freeze
    logic [15:0] dv;                     // watchdog advance across a freeze
    rsdp_core uut (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ASLEEP(ASLEEP));
    // free running clock, 8 ns
    initial forever #4 CLOCK = ~CLOCK;
    // hang guard
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    // one word transfer, address phase then data phase
    task bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {16'h0000, a};
        HWRITE <= wr;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= wd;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask : bus
    // compare and count
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // read a register and compare
    task rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask : rchk
    // reset for three cycles, then look at reset values
    task rst_chk;
        RSTN <= 1'b0;
        repeat (3) @(posedge CLOCK);
        RSTN <= 1'b1;
        rchk("flags rst", `RSDP_STATUS_ADDR, 32'h0000_0018);
        rchk("acc rst", `RSDP_WORKING_REGISTER_ADDR, 32'h0000_0000);
        $display("reset test done");
    endtask : rst_chk
    // expected {z, dc, c, result} of one operation
    function logic [10:0] model(input logic [1:0] o, input logic [7:0] wv, fr, kl,
                                input logic [2:0] s);
        logic [8:0] d;
        logic [4:0] n;
        d = {1'b0, (o == 2'd3) ? kl : fr} - {1'b0, wv};
        n = {1'b0, (o == 2'd3) ? kl[3:0] : fr[3:0]} - {1'b0, wv[3:0]};
        if (o == 2'd0) return {s[2:1], fr, s[0]};
        if (o == 2'd1) return {s[2:1], fr[0], s[0], fr[7:1]};
        return {d[7:0] == 8'h00, ~n[4], ~d[8], d[7:0]};
    endfunction : model
    // verdict
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        rst_chk();
        for (int i = 0; i < 40; i++) begin
            rnd = {$random(seed), $random(seed)};
            {op, dd, f, w, k, fv, st} = rnd[36:0];
            if (i < 2) begin
                op = 2'd3;
                w = k + 8'(i);
            end
            hd = (op == 2'd0) ? `RSDP_OP_ROTL : (op == 2'd1) ? `RSDP_OP_ROTR : `RSDP_OP_SUBF;
            ins = (op == 2'd3) ? {`RSDP_OP_SUBL, k} : {hd, dd, f};
            e = model(op, w, fv, k, st);
            tw = (op == 2'd3) || !dd;
            bus(1'b1, `RSDP_WORKING_REGISTER_ADDR, 32'(w));
            bus(1'b1, {7'h00, f, 2'b00}, 32'(fv));
            bus(1'b1, `RSDP_STATUS_ADDR, 32'(st));
            bus(1'b1, `RSDP_INSTR_ADDR, 32'(ins));
            rchk("acc", `RSDP_WORKING_REGISTER_ADDR, 32'(tw ? e[7:0] : w));
            rchk("file", {7'h00, f, 2'b00}, 32'(tw ? fv : e[7:0]));
            rchk("flags", `RSDP_STATUS_ADDR, {27'h000_0000, 2'b11, e[10:8]});
        end
        // unknown opcode leaves the working register alone
        bus(1'b1, `RSDP_INSTR_ADDR, 32'h0000_0000);
        rchk("acc nop", `RSDP_WORKING_REGISTER_ADDR, 32'(tw ? e[7:0] : w));
        $display("operation test done");
        bus(1'b1, `RSDP_CTRL_ADDR, 32'h0000_0001);
        repeat (600) @(posedge CLOCK);
        bus(1'b0, `RSDP_WDOG_ADDR, 32'h0000_0000);
        chk("dog run", 32'h0000_0001, 32'(rd[15:8] != 8'h00));
        // freeze: only the four enabled edges around the pause may count
        v0 = rd[15:0];
        CE <= 1'b0;
        repeat (300) @(posedge CLOCK);
        CE <= 1'b1;
        bus(1'b0, `RSDP_WDOG_ADDR, 32'h0000_0000);
        dv = rd[15:0] - v0;
        chk("dog frozen", 32'h0000_0004, 32'(dv));
        bus(1'b1, `RSDP_INSTR_ADDR, 32'(`RSDP_OP_SLEEP));
        rchk("flags slp", `RSDP_STATUS_ADDR, {27'h000_0000, 2'b10, e[10:8]});
        bus(1'b0, `RSDP_WDOG_ADDR, 32'h0000_0000);
        chk("dog clear", 32'h0000_0000, 32'(rd[15:6]));
        chk("asleep", 32'h0000_0001, 32'(ASLEEP));
        bus(1'b1, `RSDP_STATUS_ADDR, 32'h0000_0018);
        rchk("flags ro", `RSDP_STATUS_ADDR, 32'h0000_0010);
        bus(1'b1, `RSDP_CTRL_ADDR, 32'h0000_0000);
        chk("awake", 32'h0000_0000, 32'(ASLEEP));
        rchk("hole", 16'h1800, 32'h0000_0000);
        $display("sleep test done");
        rst_chk();
        close_out();
    end
endmodule : testbench
